/* dv/tb_touch_mode_and_result_regs.sv */
`timescale 1ns/1ps
// Bench: the host model speaks on the bus, the bench plays the measuring front end.
module tb_touch_mode_and_result_regs;
  localparam logic [29:0] F1 = {10'h3f3, 10'h0fb, 10'h291};  // Pads 0 and 2 past touch.
  localparam logic [29:0] B1 = {10'h3ff, 10'h100, 10'h2a5};  // Reference baselines.
  localparam logic [29:0] F2 = {10'h3f8, 10'h0fb, 10'h2a0};  // Pads 0 and 2 stay in band.
  localparam logic [29:0] B2 = {10'h3ff, 10'h100, 10'h2c5};  // Pad 0 baseline moved.
  localparam logic [29:0] F3 = {10'h3eb, 10'h0ec, 10'h2c4};  // Pad 0 released, pad 1 touched.
  logic        ref_clk;
  logic        resetn;
  logic        overcurrent_in;
  logic        meas_strobe;
  logic [29:0] filt_in;
  logic [29:0] base_in;
  logic        scl_pull;
  logic        sda_pull;
  logic        sda_o;
  logic        sda_oe;
  logic        shared_pin_o;
  logic        shared_pin_oe;
  logic        measure_run;
  logic [2:0]  pad_active;
  logic        pads_tied;
  logic        pad2_sense_sel;
  logic        baseline_freeze;
  logic        ok;
  int          err_total;
  int          compares;
  // Pull-ups win unless some party pulls a line low.
  wire         sda_w = !(sda_pull || (sda_oe && !sda_o));
  wire         pin_w = !(shared_pin_oe && !shared_pin_o);
  tmr_touch_mode_regs u_tmr_touch_mode_regs (
    .ref_clk(ref_clk), .resetn(resetn), .scl_i(!scl_pull), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .shared_pin_i(pin_w), .shared_pin_o(shared_pin_o),
    .shared_pin_oe(shared_pin_oe), .overcurrent_in(overcurrent_in), .meas_strobe(meas_strobe),
    .filt_in(filt_in), .base_in(base_in), .touch_thr(24'h0a0a0a), .release_thr(24'h030303),
    .measure_run(measure_run), .pad_active(pad_active), .pads_tied(pads_tied),
    .pad2_sense_sel(pad2_sense_sel), .baseline_freeze(baseline_freeze));
  tmr_host_model u_tmr_host_model (
    .ref_clk(ref_clk), .sda_line(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull));
  // 40 MHz core clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Counts every compare and reports a mismatch at once.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_tmr_host_model.write_reg(a, d, ok);
    chk("write ack", 8'h01, {7'h00, ok});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_tmr_host_model.read_reg(a, d, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    chk($sformatf("register %h", a), exp, d);
  endtask
  // One-cycle sample pulse; three idle cycles let the interrupt latch settle.
  task automatic strobe(input logic [29:0] f, input logic [29:0] b);
    @(posedge ref_clk);
    #1;
    filt_in = f;
    base_in = b;
    meas_strobe = 1'b1;
    @(posedge ref_clk);
    #1 meas_strobe = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  // Result registers of all three pads against the samples last taken.
  task automatic chk_data(input logic [29:0] f, input logic [29:0] b);
    for (int n = 0; n < 3; n++)
    begin
      rd(8'h02 + 8'(2 * n), f[n*10 +: 8]);
      rd(8'h03 + 8'(2 * n), {6'h00, f[n*10 + 8 +: 2]});
      rd(8'h1a + 8'(n), b[n*10 + 2 +: 8]);
    end
  endtask
  // Every pad count and style, entered from stop, against the mode pins and read-back.
  task automatic t_modes();
    logic [7:0] tbl [9];
    logic [3:0] c;
    logic [2:0] p;
    logic [7:0] exp;
    tbl = '{8'h01, 8'h02, 8'h03, 8'h0f, 8'h12, 8'h23, 8'h30, 8'h7e, 8'hc0};
    rd(8'h44, 8'h00);
    foreach (tbl[i])
    begin
      wr(8'h44, 8'h00);
      wr(8'h44, tbl[i]);
      c = tbl[i][3:0];
      p = (c == 4'h0) ? 3'h0 : (c == 4'h1) ? 3'h1 : (c == 4'h2) ? 3'h3 : 3'h7;
      exp = {1'b0, c != 4'h0, p, c != 4'h0 && tbl[i][5:4] != 2'h0, c > 4'h2, tbl[i][6]};
      chk("mode pins", exp, {shared_pin_oe, measure_run, pad_active, pads_tied,
          pad2_sense_sel, baseline_freeze});
      rd(8'h44, tbl[i] & 8'h7f);
    end
    $display("test modes done");
  endtask
  // Hysteresis, stop freezing results, calibration lock and the latched interrupt.
  task automatic t_measure();
    wr(8'h44, 8'h00);
    wr(8'h44, 8'h03);
    strobe(F1, B1);
    rd(8'h00, 8'h05);
    chk_data(F1, B1);
    chk("sense pin irq", 8'h00, {7'h00, shared_pin_oe});
    strobe(F2, B1);
    rd(8'h00, 8'h05);
    wr(8'h44, 8'h00);
    strobe(F3, B2);
    chk_data(F2, B1);
    wr(8'h44, 8'h42);
    strobe(F3, B2);
    chk("irq raised", 8'h01, {7'h00, shared_pin_oe});
    rd(8'h00, 8'h02);
    chk("irq released", 8'h00, {7'h00, shared_pin_oe});
    rd(8'h1a, 8'ha9);
    rd(8'h02, 8'hc4);
    $display("test measure done");
  endtask
  // Over-current clears results and blocks run until cleared.
  task automatic t_overcur();
    wr(8'h44, 8'h00);
    wr(8'h44, 8'h03);
    strobe(F1, B1);
    overcurrent_in = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 overcurrent_in = 1'b0;
    chk("stop on fault", 8'h00, {7'h00, measure_run});
    rd(8'h00, 8'h80);
    rd(8'h02, 8'h00);
    wr(8'h44, 8'h03);
    chk("run refused", 8'h00, {7'h00, measure_run});
    wr(8'h00, 8'h80);
    rd(8'h00, 8'h00);
    wr(8'h44, 8'h03);
    chk("run after clear", 8'h01, {7'h00, measure_run});
    $display("test over-current done");
  endtask
  // Foreign address, unmapped place and read-only status bits.
  task automatic t_bus();
    u_tmr_host_model.probe(7'h15, 1'b0, ok);
    u_tmr_host_model.stop_bit();
    chk("foreign address ack", 8'h00, {7'h00, ok});
    wr(8'h10, 8'ha5);
    rd(8'h10, 8'h00);
    wr(8'h00, 8'h07);
    rd(8'h00, 8'h00);
    $display("test bus done");
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // The run needs about 50000 cycles; the limit allows 80000.
  initial
  begin
    #2000000;
    err_total++;
    $display("watchdog expired");
    end_sim();
  end
  initial
  begin
    err_total = 0;
    compares = 0;
    resetn = 1'b0;
    overcurrent_in = 1'b0;
    meas_strobe = 1'b0;
    filt_in = '0;
    base_in = '0;
    repeat (12) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    repeat (8) @(posedge ref_clk);
    t_modes();
    t_measure();
    t_overcur();
    t_bus();
    end_sim();
  end
endmodule

/* dv/tmr_host_model.sv */
`timescale 1ns/1ps
// Host on the serial bus; it only ever pulls a line low, the pull-ups do the rest.
module tmr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a,  // Address of the device under test.
  parameter int         HALF     = 10      // Cycles per half bit, above the slave's minimum.
) (
  input  wire logic ref_clk,   // Timing reference.
  input  wire logic sda_line,  // Wired data level.
  output logic      scl_pull,  // High while pulling the clock low.
  output logic      sda_pull   // High while pulling data low.
);
  // Both lines start released, so the bus idles high.
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // Lines move just after an edge so no sample in the device races them.
  task automatic tick();
    repeat (HALF) @(posedge ref_clk);
    #1;
  endtask
  // Start or repeated start: data falls while the clock is high.
  task automatic start_bit();
    sda_pull = 1'b0;
    tick();
    scl_pull = 1'b0;
    tick();
    sda_pull = 1'b1;
    tick();
    scl_pull = 1'b1;
  endtask
  // Stop: data rises while the clock is high.
  task automatic stop_bit();
    sda_pull = 1'b1;
    tick();
    scl_pull = 1'b0;
    tick();
    sda_pull = 1'b0;
    tick();
  endtask
  // One bit: data is set while the clock is low and sampled late in the high phase.
  task automatic bit_io(input logic b, output logic s);
    sda_pull = !b;
    tick();
    scl_pull = 1'b0;
    tick();
    s = sda_line;
    scl_pull = 1'b1;
  endtask
  // One byte, top bit first, then the acknowledge slot; ack is high when it read low.
  task automatic byte_io(input logic [7:0] d, input logic rel, output logic [7:0] q,
                         output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(rel, s);
    ack = !s;
  endtask
  // Start and address byte; ok tells whether the slave answered.
  task automatic probe(input logic [6:0] dev, input logic rd, output logic ok);
    logic [7:0] q;
    start_bit();
    byte_io({dev, rd}, 1'b1, q, ok);
  endtask
  // Pointer then one data byte, all in one transfer.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k0;
    logic       k1;
    logic       k2;
    probe(DEV_ADDR, 1'b0, k0);
    byte_io(a, 1'b1, q, k1);
    byte_io(d, 1'b1, q, k2);
    stop_bit();
    ok = k0 && k1 && k2;
  endtask
  // Pointer write, repeated start, one byte read and closed with a not-acknowledge.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k0;
    logic k1;
    logic k2;
    logic kn;
    probe(DEV_ADDR, 1'b0, k0);
    byte_io(a, 1'b1, d, k1);
    probe(DEV_ADDR, 1'b1, k2);
    byte_io(8'hff, 1'b1, d, kn);
    stop_bit();
    ok = k0 && k1 && k2;
  endtask
endmodule

/* dv/tmr_touch_mode_regs_properties.sv */
`timescale 1ns/1ps
// Port-level checks on mode decode, shared pin use and fault handling.
module tmr_touch_mode_regs_properties (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       shared_pin_o,
  input wire logic       shared_pin_oe,
  input wire logic       overcurrent_in,
  input wire logic       measure_run,
  input wire logic [2:0] pad_active,
  input wire logic       pads_tied,
  input wire logic       pad2_sense_sel,
  input wire logic       baseline_freeze
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // Fault held long enough to pass the synchroniser and the flag register.
  sequence s_fault_held;
    overcurrent_in [*8];
  endsequence
  // Bus clock parked high, so no register write can be landing now.
  sequence s_bus_parked;
    scl_i [*8];
  endsequence
  a_pins_pull_only: assert property (sda_o == 1'b0 && shared_pin_o == 1'b0)
    else $error("open-drain pin driven high");
  a_pad_code_legal: assert property (pad_active inside {3'h0, 3'h1, 3'h3, 3'h7}
    && measure_run == (pad_active != 3'h0)) else $error("pad set does not match run state");
  a_stop_all_quiet: assert property (!measure_run |-> !pads_tied && !pad2_sense_sel)
    else $error("stop mode with area or sense set");
  a_sense_three: assert property (pad2_sense_sel == pad_active[2])
    else $error("shared pin sense does not match three pads");
  a_sense_no_irq: assert property (pad2_sense_sel [*2] |-> !shared_pin_oe)
    else $error("interrupt driven on a sense pin");
  a_tied_running: assert property (pads_tied |-> measure_run)
    else $error("pads tied while stopped");
  a_fault_forces_stop: assert property (s_fault_held |=> !measure_run)
    else $error("still running under over-current");
  a_freeze_quiet: assert property (s_bus_parked |-> $stable(baseline_freeze))
    else $error("freeze bit moved without a bus write");
  a_irq_latched: assert property ($rose(shared_pin_oe) |=> shared_pin_oe [*8])
    else $error("interrupt did not latch");
endmodule
bind tmr_touch_mode_regs tmr_touch_mode_regs_properties u_tmr_touch_mode_regs_properties (
  .ref_clk(ref_clk), .resetn(resetn), .scl_i(scl_i), .sda_o(sda_o),
  .shared_pin_o(shared_pin_o), .shared_pin_oe(shared_pin_oe),
  .overcurrent_in(overcurrent_in), .measure_run(measure_run), .pad_active(pad_active),
  .pads_tied(pads_tied), .pad2_sense_sel(pad2_sense_sel), .baseline_freeze(baseline_freeze));

/* include/tmr_pkg.sv */
// Operation
// RULE1: Configuration is written only while in stop; the code takes writes in any mode.
// RULE2: Single-pad run, one or two pads: interrupt pin.
// RULE3: Single-pad run, three pads: pin senses pad two.
// RULE4: Area run ties enabled pads as one.
// RULE5: Area run: two pads interrupt, three pads sense.
// RULE6: Bit six freezes baseline; clear means calibrate.
// RULE7: Bits 5:4 zero single-pad, else area; stop ignores.
// RULE8: Bits 3:0 decode stop, one, two, three pads.
// RULE9: Status bits 0..2 show each pad touched.
// RULE10: Touch and release thresholds give hysteresis.
// RULE11: Status at address zero, pad bits read-only.
// RULE12: Over-current sets bit seven, clears, forces stop.
// RULE13: Over-current flag set refuses any run mode.
// RULE14: Writing one clears the over-current flag.
// RULE15: Filtered low bytes at 0x02, 0x04, 0x06.
// RULE16: Filtered high bits at 0x03, 0x05, 0x07.
// RULE17: Baseline upper eight bits at 0x1a..0x1c.
// RULE18: Stop mode measures nothing and updates nothing.
// RULE19: Configuration resets to zero, pin is interrupt.
// RULE20: Status change latches interrupt; I2C read releases.
// RULE21: Unused and undefined bits read zero.
// RULE22: Status bits of unused pads read zero.
package tmr_pkg;
  // Register addresses.
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_FILT_BASE = 8'h02;
  localparam logic [7:0] ADDR_FILT_LAST = 8'h07;
  localparam logic [7:0] ADDR_BASE0     = 8'h1a;
  localparam logic [7:0] ADDR_BASE2     = 8'h1c;
  localparam logic [7:0] ADDR_CONFIG    = 8'h44;
  // Field positions in the configuration register.
  localparam int         POS_FREEZE     = 6;
  localparam int         POS_STYLE_HI   = 5;
  localparam int         POS_STYLE_LO   = 4;
  localparam int         POS_COUNT_HI   = 3;
  // Field position of the over-current flag in the status register.
  localparam int         POS_OVERCUR    = 7;
  // Value after reset and configuration write mask.
  localparam logic [7:0] CONFIG_RESET   = 8'h00;
  localparam logic [6:0] CONFIG_MASK    = 7'h7f;
  // Electrode-enable encodings.
  localparam logic [3:0] COUNT_STOP     = 4'h0;
  localparam logic [3:0] COUNT_ONE      = 4'h1;
  localparam logic [3:0] COUNT_TWO      = 4'h2;
  // Serial bit counter value at a full byte.
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  // Serial slave states, one-hot.
  typedef enum logic [6:0] {
    ST_IDLE     = 7'b0000001,
    ST_ADDR     = 7'b0000010,
    ST_ADDR_ACK = 7'b0000100,
    ST_WDATA    = 7'b0001000,
    ST_WACK     = 7'b0010000,
    ST_RDATA    = 7'b0100000,
    ST_RACK     = 7'b1000000
  } tmr_state_type;
endpackage

/* logic/tmr_touch_mode_regs.sv */
`timescale 1ns/1ps
module tmr_touch_mode_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary bus address; set per system.
) (
  input  wire logic        ref_clk,          // Core clock, 40 MHz.
  input  wire logic        resetn,           // Synchronous reset, active low.
  input  wire logic        scl_i,            // Serial clock pin level.
  input  wire logic        sda_i,            // Serial data pin level.
  output logic             sda_o,            // Serial data drive value, always low.
  output logic             sda_oe,           // High while pulling serial data low.
  input  wire logic        shared_pin_i,     // Shared interrupt or pad two pin level.
  output logic             shared_pin_o,     // Shared pin drive value, always low.
  output logic             shared_pin_oe,    // High while interrupt pulls the pin low.
  input  wire logic        overcurrent_in,   // Reference resistor current excess, async.
  input  wire logic        meas_strobe,      // One-cycle pulse: new sample set ready.
  input  wire logic [29:0] filt_in,          // Filtered data, 10 bits per pad.
  input  wire logic [29:0] base_in,          // Baseline data, 10 bits per pad.
  input  wire logic [23:0] touch_thr,        // Touch thresholds, 8 bits per pad.
  input  wire logic [23:0] release_thr,      // Release thresholds, 8 bits per pad.
  output logic             measure_run,      // High while the front end may measure.
  output logic [2:0]       pad_active,       // Pads the front end should sense.
  output logic             pads_tied,        // High when pads join into one area.
  output logic             pad2_sense_sel,   // High when shared pin senses pad two.
  output logic             baseline_freeze   // High when baseline tracking stops.
);

  // Three-stage synchronisers for pin inputs.
  logic [2:0]  scl_sync_reg;
  logic [2:0]  sda_sync_reg;
  logic [2:0]  oc_sync_reg;
  logic        scl_s_reg;                    // Debounced serial clock.
  logic        sda_s_reg;                    // Debounced serial data.
  logic        scl_d_reg;                    // Previous debounced clock.
  logic        sda_d_reg;                    // Previous debounced data.
  logic        oc_s_reg;                     // Debounced over-current level.
  // Register contents.
  logic [6:0]  config_reg;                   // Freeze, style and count fields.
  logic        overcur_reg;                  // Over-current flag.
  logic [2:0]  touched_reg;                  // Raw touched state per pad.
  logic [29:0] filt_reg;                     // Filtered data per pad.
  logic [29:0] base_reg;                     // Full baseline per pad.
  logic        irq_latch_reg;                // Latched interrupt.
  // Serial slave.
  tmr_pkg::tmr_state_type state_reg;
  logic [3:0]  bitcnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  ptr_reg;
  logic        first_reg;                    // Next written byte is the pointer.
  logic        rw_reg;                       // Current transfer is a read.
  logic        nack_reg;                     // Master refused the last byte.
  logic        wr_stb_reg;                   // One-cycle register write pulse.
  logic [7:0]  wr_addr_reg;
  logic [7:0]  wr_data_reg;
  logic        rd_stb_reg;                   // One-cycle read-start pulse.
  logic [7:0]  rd_data;
  logic [2:0]  status_vis;                   // Status bits as the host sees them.
  logic [2:0]  status_prev_reg;
  logic        running;
  logic        area_mode;
  logic        pin_is_irq;
  logic [2:0]  pads_on;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic [7:0]  shift_next;
  logic [7:0]  rd_next;                      // Read data for the address after ptr.

  // Pin synchronisers; a level is accepted once stages two and three agree.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      oc_sync_reg  <= 3'h0;
      scl_s_reg    <= 1'b1;
      sda_s_reg    <= 1'b1;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
      oc_s_reg     <= 1'b0;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      oc_sync_reg  <= {oc_sync_reg[1:0], overcurrent_in};
      if (scl_sync_reg[1] == scl_sync_reg[2])
        scl_s_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2])
        sda_s_reg <= sda_sync_reg[2];
      if (oc_sync_reg[1] == oc_sync_reg[2])
        oc_s_reg <= oc_sync_reg[2];
      scl_d_reg <= scl_s_reg;
      sda_d_reg <= sda_s_reg;
    end
  end

  // Mode decode from the configuration register.
  always_comb
  begin
    running    = (config_reg[tmr_pkg::POS_COUNT_HI:0] != tmr_pkg::COUNT_STOP);  // RULE8
    // The style field only matters when running, so stop ignores it.
    area_mode  = running && (config_reg[tmr_pkg::POS_STYLE_HI:tmr_pkg::POS_STYLE_LO] != 2'b00);  // RULE7
    // Count one or two, and stop, leave the shared pin as the interrupt.
    pin_is_irq = (config_reg[tmr_pkg::POS_COUNT_HI:0] == tmr_pkg::COUNT_STOP) ||
                 (config_reg[tmr_pkg::POS_COUNT_HI:0] == tmr_pkg::COUNT_ONE) ||
                 (config_reg[tmr_pkg::POS_COUNT_HI:0] == tmr_pkg::COUNT_TWO);  // RULE2 RULE3 RULE5
    if (!running)
      pads_on = 3'b000;
    else if (config_reg[tmr_pkg::POS_COUNT_HI:0] == tmr_pkg::COUNT_ONE)
      pads_on = 3'b001;
    else if (config_reg[tmr_pkg::POS_COUNT_HI:0] == tmr_pkg::COUNT_TWO)
      pads_on = 3'b011;
    else
      pads_on = 3'b111;
    // In area mode the combined pad reports on bit zero only.
    if (area_mode)
      status_vis = {2'b00, touched_reg[0]};  // RULE4
    else
      status_vis = touched_reg & pads_on;  // RULE22
  end

  // Front-end control outputs, registered.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      measure_run     <= 1'b0;
      pad_active      <= 3'b000;
      pads_tied       <= 1'b0;
      pad2_sense_sel  <= 1'b0;
      baseline_freeze <= 1'b0;
      shared_pin_oe   <= 1'b0;
    end
    else
    begin
      measure_run     <= running;  // RULE18
      pad_active      <= pads_on;
      pads_tied       <= area_mode;  // RULE4
      pad2_sense_sel  <= !pin_is_irq;  // RULE3 RULE5
      baseline_freeze <= config_reg[tmr_pkg::POS_FREEZE];  // RULE6
      shared_pin_oe   <= pin_is_irq && irq_latch_reg;  // RULE2
    end
  end

  assign sda_o        = 1'b0;
  assign shared_pin_o = 1'b0;

  // Configuration register; over-current forces and holds stop.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      config_reg <= tmr_pkg::CONFIG_RESET[6:0];  // RULE19
    else if (oc_s_reg || overcur_reg)
      config_reg[tmr_pkg::POS_COUNT_HI:0] <= tmr_pkg::COUNT_STOP;  // RULE12 RULE13
    else if (wr_stb_reg && wr_addr_reg == tmr_pkg::ADDR_CONFIG)
      // Any write is taken unless over-current is present or flagged; software keeps writes to stop mode first.
      config_reg <= wr_data_reg[6:0] & tmr_pkg::CONFIG_MASK;  // RULE1 RULE21
  end

  // Over-current flag: a new event wins over a clearing write.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      overcur_reg <= 1'b0;
    else if (oc_s_reg)
      overcur_reg <= 1'b1;  // RULE12
    else if (wr_stb_reg && wr_addr_reg == tmr_pkg::ADDR_STATUS &&
             wr_data_reg[tmr_pkg::POS_OVERCUR])
      overcur_reg <= 1'b0;  // RULE14
  end

  // Measurement capture and hysteresis, one slice per pad.
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_pad
      logic signed [10:0] delta;             // Baseline minus filtered sample.
      assign delta = $signed({1'b0, base_in[g*10 +: 10]}) -
                     $signed({1'b0, filt_in[g*10 +: 10]});
      always_ff @(posedge ref_clk)
      begin
        if (!resetn || oc_s_reg)
        begin
          touched_reg[g]       <= 1'b0;  // RULE12
          filt_reg[g*10 +: 10] <= 10'h000;
          base_reg[g*10 +: 10] <= 10'h000;
        end
        else if (meas_strobe && running && pads_on[g])  // RULE18
        begin
          filt_reg[g*10 +: 10] <= filt_in[g*10 +: 10];
          if (!config_reg[tmr_pkg::POS_FREEZE])
            base_reg[g*10 +: 10] <= base_in[g*10 +: 10];  // RULE6
          // Enter touch above the touch level, leave below the release level.
          if (!touched_reg[g] && delta > $signed({3'b000, touch_thr[g*8 +: 8]}))
            touched_reg[g] <= 1'b1;  // RULE10
          else if (touched_reg[g] && delta < $signed({3'b000, release_thr[g*8 +: 8]}))
            touched_reg[g] <= 1'b0;  // RULE10
        end
      end
    end
  endgenerate

  // Interrupt latch: a status change wins over a releasing read.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      irq_latch_reg   <= 1'b0;
      status_prev_reg <= 3'b000;
    end
    else
    begin
      status_prev_reg <= status_vis;
      if (status_vis != status_prev_reg)
        irq_latch_reg <= 1'b1;  // RULE20
      else if (rd_stb_reg)
        irq_latch_reg <= 1'b0;  // RULE20
    end
  end

  // Read decode; unmapped addresses read zero.
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == tmr_pkg::ADDR_STATUS)
      v = {overcur_reg, 4'h0, status_vis};  // RULE9 RULE11 RULE21
    else if (a >= tmr_pkg::ADDR_FILT_BASE && a <= tmr_pkg::ADDR_FILT_LAST)
    begin
      if (a[0] == 1'b0)
        v = filt_reg[(a[2:1] - 2'd1) * 10 +: 8];  // RULE15
      else
        v = {6'h00, filt_reg[(a[2:1] - 2'd1) * 10 + 8 +: 2]};  // RULE16 RULE21
    end
    else if (a >= tmr_pkg::ADDR_BASE0 && a <= tmr_pkg::ADDR_BASE2)
      v = base_reg[2'(a[1:0] - 2'd2) * 10 + 2 +: 8];  // RULE17
    else if (a == tmr_pkg::ADDR_CONFIG)
      v = {1'b0, config_reg};  // RULE21
    return v;
  endfunction

  always_comb
  begin
    rd_data    = reg_read(ptr_reg);
    rd_next    = reg_read(ptr_reg + 8'h01);
    scl_rise   = scl_s_reg && !scl_d_reg;
    scl_fall   = !scl_s_reg && scl_d_reg;
    bus_start  = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
    bus_stop   = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;
    shift_next = {shift_reg[6:0], sda_s_reg};
  end

  // Serial slave: address byte, pointer byte, then data with auto-increment.
  // The bus is slow against the core clock, so an edge is seen many cycles apart.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state_reg   <= tmr_pkg::ST_IDLE;
      bitcnt_reg  <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      ptr_reg     <= 8'h00;
      first_reg   <= 1'b0;
      rw_reg      <= 1'b0;
      nack_reg    <= 1'b0;
      sda_oe      <= 1'b0;
      wr_stb_reg  <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      rd_stb_reg  <= 1'b0;
    end
    else
    begin
      wr_stb_reg <= 1'b0;
      rd_stb_reg <= 1'b0;
      if (bus_start)
      begin
        state_reg  <= tmr_pkg::ST_ADDR;
        bitcnt_reg <= 4'h0;
        sda_oe     <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_reg <= tmr_pkg::ST_IDLE;
        sda_oe    <= 1'b0;
      end
      else
      begin
        case (state_reg)
          tmr_pkg::ST_ADDR, tmr_pkg::ST_WDATA:
          begin
            if (scl_rise)
            begin
              shift_reg  <= shift_next;
              bitcnt_reg <= bitcnt_reg + 4'h1;
            end
            else if (scl_fall && bitcnt_reg == tmr_pkg::BITS_PER_BYTE)
            begin
              if (state_reg == tmr_pkg::ST_ADDR)
              begin
                if (shift_reg[7:1] == DEV_ADDR)
                begin
                  sda_oe     <= 1'b1;
                  rw_reg     <= shift_reg[0];
                  first_reg  <= 1'b1;
                  tx_reg     <= rd_data;
                  rd_stb_reg <= shift_reg[0];  // RULE20
                  state_reg  <= tmr_pkg::ST_ADDR_ACK;
                end
                else
                  state_reg <= tmr_pkg::ST_IDLE;
              end
              else
              begin
                sda_oe    <= 1'b1;
                first_reg <= 1'b0;
                state_reg <= tmr_pkg::ST_WACK;
                if (first_reg)
                  ptr_reg <= shift_reg;
                else
                begin
                  wr_stb_reg  <= 1'b1;
                  wr_addr_reg <= ptr_reg;
                  wr_data_reg <= shift_reg;
                  ptr_reg     <= ptr_reg + 8'h01;
                end
              end
            end
          end
          tmr_pkg::ST_ADDR_ACK, tmr_pkg::ST_WACK:
          begin
            if (scl_fall)
            begin
              bitcnt_reg <= 4'h0;
              if (state_reg == tmr_pkg::ST_ADDR_ACK && rw_reg)
              begin
                sda_oe    <= !tx_reg[7];
                state_reg <= tmr_pkg::ST_RDATA;
              end
              else
              begin
                sda_oe    <= 1'b0;
                state_reg <= tmr_pkg::ST_WDATA;
              end
            end
          end
          tmr_pkg::ST_RDATA:
          begin
            if (scl_rise)
              bitcnt_reg <= bitcnt_reg + 4'h1;
            else if (scl_fall)
            begin
              if (bitcnt_reg == tmr_pkg::BITS_PER_BYTE)
              begin
                sda_oe    <= 1'b0;
                state_reg <= tmr_pkg::ST_RACK;
              end
              else
              begin
                sda_oe <= !tx_reg[6];
                tx_reg <= {tx_reg[6:0], 1'b0};
              end
            end
          end
          tmr_pkg::ST_RACK:
          begin
            if (scl_rise)
              nack_reg <= sda_s_reg;
            else if (scl_fall)
            begin
              if (nack_reg)
                state_reg <= tmr_pkg::ST_IDLE;
              else
              begin
                // Next byte of a burst comes from the following address.
                ptr_reg    <= ptr_reg + 8'h01;
                tx_reg     <= rd_next;
                sda_oe     <= !rd_next[7];
                bitcnt_reg <= 4'h0;
                state_reg  <= tmr_pkg::ST_RDATA;
              end
            end
          end
          default:
            state_reg <= tmr_pkg::ST_IDLE;
        endcase
      end
    end
  end

endmodule
